// file: rtl/adgc_consts.svh
// Bit positions, reset values and sizes for the digital I/O and gate control block
`ifndef ADGC_CONSTS_SVH
`define ADGC_CONSTS_SVH
`define ADGC_CFG_STATUS 0
`define ADGC_CFG_STEP 1
`define ADGC_CFG_INVERT 2
`define ADGC_CFG_PUSHPULL 3
`define ADGC_CFG_TRIG_LO 4
`define ADGC_CFG_GATE_WATCH 8
`define ADGC_CFG_GATE_REL 9
`define ADGC_CFG_GATE_LOW 10
`define ADGC_CFG_CLR_TRIG 11
`define ADGC_NUM_SYS 4
`define ADGC_VAL_RST 8'h00
`define ADGC_PIN_RST 8'h00
`define ADGC_SYNC_RST 8'hff
`endif

// file: rtl/adgc_pkg.sv
// Types for the digital I/O and gate control block
package adgc_pkg;
	typedef enum logic [2:0] {
		ADGC_IDLE = 3'b001,
		ADGC_ARMED = 3'b010,
		ADGC_RUN = 3'b100
	} adgc_sys_t;

	typedef struct packed {
		logic [7:0] pinOut;
		logic [7:0] pinOe;
		logic [3:0] runOut;
		logic [3:0] clearOut;
		logic gateOut;
		logic gateOe;
		logic [7:0] value;
		logic [7:0] syncA;
		logic [7:0] syncB;
		logic [7:0] trigPrev;
		logic [3:0] runPrev;
		logic [3:0] running;
		adgc_sys_t [3:0] sysState;
	} adgc_state_t;
endpackage : adgc_pkg

// file: rtl/acq_digio_gate_control.sv
// Digital I/O port, external trigger start and gate line control
//
// Function
// RULE_01: Status mode drives each system's pin high while running, low while idle.
// RULE_02: Invert option flips the level on status or value pins.
// RULE_03: Value mode presents a loadable 8-bit value on the I/O port.
// RULE_04: Value mode adds one to the output value whenever acquisition stops.
// RULE_05: Pins drive push-pull or open-drain as configuration selects.
// RULE_06: Trigger enable makes inputs 4..7 trigger systems 1..4.
// RULE_07: With trigger enabled, start command only arms monitoring of the input.
// RULE_08: While armed, a high-to-low input clears the system then starts it; code clears only with bit 11 set or erase, same edge as sysRun.
// RULE_09: Input returning high stops; inverted if set; next change restarts.
// RULE_10: A stop command ends trigger monitoring for that system.
// RULE_11: Clear-before-start option erases spectrum before each triggered start.
// RULE_12: Gate line gates acquisition; watch, gate_release_on_run, low-at-preset options; the code only reports the gate input on gateSeen with watch set.
// RULE_13: Low-at-preset pulls the gate line low at once on sweep preset.
// RULE_14: Up to four systems, each started, stopped, erased by one command.
// RULE_15: Config bits: 0 status, 1 value, 2 invert, 3 push-pull, 4..7 trigger, 8 watch.
// RULE_16: Config bit 9 gate_release_on_run, 10 low at preset, 11 clear before trigger.
// RULE_17: Gate_release_on_run lets the gate line go high when acquisition begins.
`timescale 1ns/1ps
`include "adgc_consts.svh"
module acq_digio_gate_control
	import adgc_pkg::*;
#(
	parameter int NUM_SYS = `ADGC_NUM_SYS
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [11:0] digioConfig,
	input wire logic [7:0] valueLoad,
	input wire logic valueLoadStb,
	input wire logic [3:0] startCmd,
	input wire logic [3:0] stopCmd,
	input wire logic [3:0] eraseCmd,
	input wire logic [3:0] acqDone,
	input wire logic sweepPresetHit,
	input wire logic [7:0] digioIn,
	input wire logic gateLineIn,
	output logic [7:0] digioOut,
	output logic [7:0] digioOe,
	output logic [3:0] sysRun,
	output logic [3:0] sysClear,
	output logic [7:0] stepValue,
	output logic gateOut,
	output logic gateOe,
	output logic gateSeen
);
	adgc_state_t s_q, s_d;
	logic gateSyncA_q, gateSync_q;

	logic statusMode, stepMode, invert, pushPull, watch, gateRel, gateLow, clrTrig;
	logic [3:0] trigEn;
	always_comb begin
		statusMode = digioConfig[`ADGC_CFG_STATUS]; // RULE_15
		stepMode = digioConfig[`ADGC_CFG_STEP];
		invert = digioConfig[`ADGC_CFG_INVERT];
		pushPull = digioConfig[`ADGC_CFG_PUSHPULL];
		trigEn = digioConfig[`ADGC_CFG_TRIG_LO +: 4];
		watch = digioConfig[`ADGC_CFG_GATE_WATCH];
		gateRel = digioConfig[`ADGC_CFG_GATE_REL]; // RULE_16
		gateLow = digioConfig[`ADGC_CFG_GATE_LOW];
		clrTrig = digioConfig[`ADGC_CFG_CLR_TRIG];
	end

	logic [7:0] levelOut;
	logic [3:0] trigLvl, trigFall, trigRise, startEdge, stopEdge;
	always_comb begin
		s_d = s_q;
		s_d.syncA = digioIn;
		s_d.syncB = s_q.syncA;
		s_d.trigPrev = s_q.syncB;
		s_d.clearOut = 4'h0;
		// Active level of the trigger; inversion swaps which edge starts the run
		trigLvl = s_q.syncB[7:4] ^ {4{invert}}; // RULE_06 RULE_09
		trigFall = s_q.trigPrev[7:4] & ~s_q.syncB[7:4];
		trigRise = ~s_q.trigPrev[7:4] & s_q.syncB[7:4];
		if (invert) begin
			trigFall = ~s_q.trigPrev[7:4] & s_q.syncB[7:4];
			trigRise = s_q.trigPrev[7:4] & ~s_q.syncB[7:4];
		end
		for (int i = 0; i < NUM_SYS; i++) begin
			unique case (s_q.sysState[i])
				ADGC_IDLE: begin
					if (startCmd[i] && !stopCmd[i]) begin
						if (trigEn[i]) begin
							s_d.sysState[i] = ADGC_ARMED; // RULE_07
						end else begin
							s_d.sysState[i] = ADGC_RUN;
							s_d.running[i] = 1'b1; // RULE_14
						end
					end
				end
				ADGC_ARMED: begin
					if (stopCmd[i]) begin
						s_d.sysState[i] = ADGC_IDLE; // RULE_10
						s_d.running[i] = 1'b0;
					end else if (s_q.running[i]) begin
						if (trigRise[i] || acqDone[i]) begin
							s_d.running[i] = 1'b0; // RULE_09
						end
					end else if (trigFall[i]) begin
						s_d.clearOut[i] = 1'b1; // RULE_08 RULE_11
						s_d.running[i] = 1'b1;
					end
				end
				ADGC_RUN: begin
					if (stopCmd[i] || acqDone[i]) begin
						s_d.sysState[i] = ADGC_IDLE; // RULE_14
						s_d.running[i] = 1'b0;
					end
				end
				default: begin
					s_d.sysState[i] = ADGC_IDLE;
					s_d.running[i] = 1'b0;
				end
			endcase
			if (eraseCmd[i]) begin
				s_d.clearOut[i] = 1'b1; // RULE_14
			end
		end
		// Triggered start clears only with the option set or an erase pending
		s_d.clearOut = s_d.clearOut & (eraseCmd | {4{clrTrig}} | ~trigEn);
		s_d.runOut = s_d.running;
		s_d.runPrev = s_q.running;
		startEdge = s_q.running & ~s_q.runPrev;
		stopEdge = s_q.runPrev & ~s_q.running;
		// Load wins over step so software always sees its value
		if (valueLoadStb) begin
			s_d.value = valueLoad; // RULE_03
		end else if (stepMode && (|stopEdge)) begin
			s_d.value = s_q.value + 8'h01; // RULE_04
		end
		levelOut = 8'h00;
		if (stepMode) begin
			levelOut = s_d.value; // RULE_03
		end else if (statusMode) begin
			levelOut = {4'h0, s_d.running}; // RULE_01
		end
		levelOut = levelOut ^ {8{invert}}; // RULE_02
		s_d.pinOut = levelOut;
		if (!(statusMode || stepMode)) begin
			s_d.pinOe = 8'h00;
		end else if (pushPull) begin
			s_d.pinOe = 8'hff; // RULE_05
		end else begin
			s_d.pinOe = ~levelOut; // RULE_05
		end
		// Upper pins stay inputs in status mode; value mode drives all eight
		if (statusMode && !stepMode) begin
			s_d.pinOe[7:4] = 4'h0;
		end
		// Gate is open drain: only ever pulled low, released to float high
		s_d.gateOut = 1'b0;
		if (gateLow && sweepPresetHit) begin
			s_d.gateOe = 1'b1; // RULE_13
		end else if (gateRel && (|startEdge)) begin
			s_d.gateOe = 1'b0; // RULE_12 RULE_17
		end else if (gateRel && !(|s_q.running) && !gateLow) begin
			s_d.gateOe = 1'b1; // RULE_12
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '{pinOut: `ADGC_PIN_RST, pinOe: 8'h00, runOut: 4'h0, clearOut: 4'h0,
				// Idle pins float high; a low reset value would fake an edge
				gateOut: 1'b0, gateOe: 1'b0, value: `ADGC_VAL_RST, syncA: `ADGC_SYNC_RST,
				syncB: `ADGC_SYNC_RST, trigPrev: `ADGC_SYNC_RST, runPrev: 4'h0, running: 4'h0,
				sysState: {4{ADGC_IDLE}}};
			gateSyncA_q <= 1'b1;
			gateSync_q <= 1'b1;
		end else begin
			s_q <= s_d;
			gateSyncA_q <= gateLineIn;
			gateSync_q <= gateSyncA_q;
		end
	end

	logic gateSeen_q;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			gateSeen_q <= 1'b0;
		end else begin
			gateSeen_q <= watch & gateSync_q; // RULE_12
		end
	end

	always_comb begin
		digioOut = s_q.pinOut;
		digioOe = s_q.pinOe;
		sysRun = s_q.runOut;
		sysClear = s_q.clearOut;
		stepValue = s_q.value;
		gateOut = s_q.gateOut;
		gateOe = s_q.gateOe;
		gateSeen = gateSeen_q;
	end
endmodule : acq_digio_gate_control

// file: bench/adgc_monitor.sv
// Port checker for the digital I/O and gate control block
`timescale 1ns/1ps
module adgc_monitor (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [11:0] digioConfig,
	input wire logic valueLoadStb,
	input wire logic [3:0] startCmd,
	input wire logic [3:0] stopCmd,
	input wire logic sweepPresetHit,
	input wire logic [7:0] digioOut,
	input wire logic [7:0] digioOe,
	input wire logic [3:0] sysRun,
	input wire logic [7:0] stepValue,
	input wire logic gateOe
);
	wire logic [11:0] c = digioConfig;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	property p_run; startCmd[0] && !stopCmd[0] && !c[4] && !sysRun[0] |=> sysRun[0]; endproperty
	a_run: assert property (p_run) else $error("start lost");
	property p_stop; stopCmd[0] |=> !sysRun[0]; endproperty
	a_stop: assert property (p_stop) else $error("stop lost");
	property p_arm; startCmd[0] && c[4] && !sysRun[0] |=> !sysRun[0]; endproperty
	a_arm: assert property (p_arm) else $error("armed start ran");
	// Past reset guard: outputs lag a config change by one edge
	property p_stat; c[0] && !c[1] && $stable(c) && $past(rst_n) |->
		digioOut[0] == (sysRun[0] ^ c[2]); endproperty
	a_stat: assert property (p_stat) else $error("status pin");
	property p_val; c[1] && $stable(c) && $past(rst_n) |->
		digioOut == (stepValue ^ {8{c[2]}}); endproperty
	a_val: assert property (p_val) else $error("value pins");
	property p_inc; c[1] && $fell(sysRun[0]) && !valueLoadStb |=>
		stepValue == 8'($past(stepValue) + 8'h01); endproperty
	a_inc: assert property (p_inc) else $error("no step");
	property p_oe; c[1] && $stable(c) && $past(rst_n) |->
		digioOe == (c[3] ? 8'hFF : ~digioOut); endproperty
	a_oe: assert property (p_oe) else $error("pin enable");
	property p_pre; sweepPresetHit && c[10] |=> gateOe; endproperty
	a_pre: assert property (p_pre) else $error("gate not low");
endmodule : adgc_monitor
bind acq_digio_gate_control adgc_monitor u_adgc_monitor (.mclk(mclk), .rst_n(rst_n),
	.digioConfig(digioConfig), .valueLoadStb(valueLoadStb), .startCmd(startCmd),
	.stopCmd(stopCmd), .sweepPresetHit(sweepPresetHit), .digioOut(digioOut),
	.digioOe(digioOe), .sysRun(sysRun), .stepValue(stepValue), .gateOe(gateOe));

// file: bench/adgc_changer.sv
// Sample changer model: pulled-up pins, trigger line on pin 4
`timescale 1ns/1ps
module adgc_changer (
	input wire logic [7:0] digioOut,
	input wire logic [7:0] digioOe,
	input wire logic trigLevel,
	input wire logic gateOe,
	output wire logic [7:0] digioIn,
	output wire logic gateLineIn
);
	// Released pins float up, never hold the last value
	wire logic [7:0] pinLvl = (digioOut & digioOe) | ~digioOe;
	assign digioIn = {pinLvl[7:5], pinLvl[4] & trigLevel, pinLvl[3:0]};
	assign gateLineIn = ~gateOe;
endmodule : adgc_changer

// file: bench/acq_digio_gate_control_tb_top.sv
// Self-checking bench for the digital I/O and gate control block
`timescale 1ns/1ps
module acq_digio_gate_control_tb_top;
	logic mclk = 0, rst_n = 0, valueLoadStb = 0, sweepPresetHit = 0, trig = 1, clrSeen = 0;
	logic [11:0] cfg = 12'h000;
	logic [7:0] valueLoad = 8'h00, digioIn, digioOut, digioOe, stepValue;
	logic [3:0] startCmd = 4'h0, stopCmd = 4'h0, sysRun, sysClear;
	logic gateOe, gateSeen, gateLineIn, gateOut;
	int num_errors = 0, cmp_count = 0, cyc = 0;
	acq_digio_gate_control u_acq_digio_gate_control (.mclk(mclk), .rst_n(rst_n),
		.digioConfig(cfg), .valueLoad(valueLoad), .valueLoadStb(valueLoadStb),
		.startCmd(startCmd), .stopCmd(stopCmd), .eraseCmd(4'h0), .acqDone(4'h0),
		.sweepPresetHit(sweepPresetHit), .digioIn(digioIn), .gateLineIn(gateLineIn),
		.digioOut(digioOut), .digioOe(digioOe), .sysRun(sysRun), .sysClear(sysClear),
		.stepValue(stepValue), .gateOut(gateOut), .gateOe(gateOe), .gateSeen(gateSeen));
	adgc_changer u_adgc_changer (.digioOut(digioOut), .digioOe(digioOe),
		.trigLevel(trig), .gateOe(gateOe), .digioIn(digioIn), .gateLineIn(gateLineIn));
	initial forever #20 mclk = ~mclk;
	always @(posedge mclk) begin
		clrSeen <= clrSeen | sysClear[0];
		cyc++;
		if (cyc == 3000) begin
			num_errors++;
			test_done();
		end
	end
	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("unexpected %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task cmd(input logic s);
		@(negedge mclk);
		startCmd[0] = s;
		stopCmd[0] = !s;
		@(negedge mclk);
		startCmd = 4'h0;
		stopCmd = 4'h0;
		repeat (5) @(negedge mclk);
	endtask : cmd
	task test_done;
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : test_done
	initial begin
		repeat (3) @(negedge mclk);
		rst_n = 1;
		cfg = 12'h009;
		cmd(1);
		chk("run", 8'h01, 8'(sysRun));
		chk("stat", 8'h01, digioOut & 8'h0F);
		cmd(0);
		chk("stat", 8'h00, digioOut & 8'h0F);
		cfg = 12'h00D;
		repeat (3) @(negedge mclk);
		chk("inv", 8'h0F, digioOut & 8'h0F);
		$display("status test done");
		cfg = 12'h00A;
		valueLoad = 8'hFF;
		valueLoadStb = 1;
		@(negedge mclk);
		valueLoadStb = 0;
		repeat (2) @(negedge mclk);
		chk("val", 8'hFF, digioOut);
		cmd(1);
		cmd(0);
		chk("wrap", 8'h00, stepValue);
		cfg = 12'h002;
		repeat (3) @(negedge mclk);
		chk("od", 8'hFF, digioOe);
		$display("value test done");
		// Trigger on pin 4, clear before start
		cfg = 12'h811;
		cmd(1);
		chk("arm", 8'h00, 8'(sysRun));
		trig = 0;
		repeat (5) @(negedge mclk);
		chk("trig", 8'h01, 8'(sysRun));
		chk("clr", 8'h01, 8'(clrSeen));
		trig = 1;
		repeat (5) @(negedge mclk);
		chk("off", 8'h00, 8'(sysRun));
		trig = 0;
		repeat (5) @(negedge mclk);
		chk("rerun", 8'h01, 8'(sysRun));
		cmd(0);
		trig = 1;
		repeat (5) @(negedge mclk);
		trig = 0;
		repeat (5) @(negedge mclk);
		chk("disarm", 8'h00, 8'(sysRun));
		$display("trigger test done");
		cfg = 12'h600;
		sweepPresetHit = 1;
		@(negedge mclk);
		sweepPresetHit = 0;
		@(negedge mclk);
		chk("low", 8'h01, 8'(gateOe));
		cfg = 12'h300;
		cmd(1);
		chk("rel", 8'h00, 8'(gateOe));
		chk("watch", 8'h01, 8'(gateSeen));
		chk("gout", 8'h00, 8'(gateOut));
		$display("gate test done");
		test_done();
	end
endmodule : acq_digio_gate_control_tb_top
